// File: hw/tofm_consts.vh
// Constants for the timer overflow and match/capture D flag block.
// Assumes an APB slave with 32-bit data; all offsets are byte addresses.
`ifndef TOFM_CONSTS_VH
`define TOFM_CONSTS_VH
`define TOFM_STATUS_OFS   12'h000
`define TOFM_CONTROL_OFS  12'h004
`define TOFM_COUNTER_OFS  12'h008
`define TOFM_GRD_OFS      12'h00C
`define TOFM_BIT_FLAG_D   3
`define TOFM_BIT_OVF      4
`define TOFM_BIT_CAPMODE  0
`define TOFM_CNT_MAX      16'hFFFF
`define TOFM_CNT_ZERO     16'h0000
`define TOFM_CTRL_RST     32'h0000_0000
`define TOFM_GRD_RST      16'hFFFF
`define TOFM_RDATA_RST    32'h0000_0000
`endif

// File: hw/tofm_flags.v
// Status flags: counter overflow and match/capture flag D, with APB registers.
// Assumes counter value and capture strobe come from same-clock timer logic.
`timescale 1ns/10ps
`include "tofm_consts.vh"
module tofm_flags #(
	parameter CHANNEL = 0
) (
	input  wire        ref_clk_i,
	input  wire        rst_n_i,
	input  wire        clk_en_i,
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [11:0] paddr_i,
	input  wire [31:0] pwdata_i,
	output wire        pready_o,
	output wire        pslverr_o,
	output reg  [31:0] prdata_o,
	input  wire [15:0] timer_up_counter_i,
	input  wire        capture_strobe_i,
	input  wire        xfer_start_i,
	input  wire        transfer_interrupt_select_i,
	input  wire        transfer_count_nonzero_i,
	output wire        counter_overflow_flag_o,
	output wire        match_capture_flag_d_o,
	output wire        match_capture_interrupt_d_o
);
	localparam [0:0] HAS_D = (CHANNEL == 0);

	// Remembered state
	reg  [15:0] cnt_prev_q;
	reg  [15:0] general_register_d_q;
	reg         capmode_q;
	reg         ovf_q;
	reg         flgd_q;
	reg         ovf_seen_q;
	reg         flgd_seen_q;
	reg         match_prev_q;
	reg         rd_loaded_q;
	reg  [31:0] rd_word_d;

	// Bus decode and flag events
	wire        acc;
	wire        wr;
	wire        rd;
	wire        rd_fetch;
	wire        sts;
	wire        ctl;
	wire        grd;
	wire        match;
	wire        match_rise;
	wire        ovf_set;
	wire        d_set;
	wire        ovf_clr;
	wire        d_sw_clr;
	wire        d_hw_clr;
	wire        d_clr;
	wire        seen_ovf;
	wire        seen_d;

	// A read word is fetched before the access edge, so it stands there;
	// pready stays low until that fetch has happened on an enabled edge
	assign pready_o = clk_en_i & (pwrite_i | rd_loaded_q);
	assign pslverr_o = 1'b0;
	assign acc = psel_i & penable_i & pready_o;
	assign wr = acc & pwrite_i;
	assign rd = acc & ~pwrite_i;
	assign rd_fetch = psel_i & ~pwrite_i & ~rd;
	assign sts = (paddr_i == `TOFM_STATUS_OFS);
	assign ctl = (paddr_i == `TOFM_CONTROL_OFS);
	assign grd = (paddr_i == `TOFM_GRD_OFS);
	assign match = (timer_up_counter_i == general_register_d_q);
	assign match_rise = match & ~match_prev_q;
	assign ovf_set = (cnt_prev_q == `TOFM_CNT_MAX) &
		(timer_up_counter_i == `TOFM_CNT_ZERO);
	assign d_set = HAS_D &
		(capmode_q ? capture_strobe_i : match_rise);
	assign ovf_clr = wr & sts & ovf_seen_q &
		~pwdata_i[`TOFM_BIT_OVF];
	assign d_sw_clr = HAS_D & wr & sts & flgd_seen_q &
		~pwdata_i[`TOFM_BIT_FLAG_D];
	assign d_hw_clr = xfer_start_i & ~transfer_interrupt_select_i &
		transfer_count_nonzero_i;
	assign d_clr = d_sw_clr | d_hw_clr;
	// Arming follows the value that the read actually returned
	assign seen_ovf = rd & sts & prdata_o[`TOFM_BIT_OVF];
	assign seen_d = rd & sts & prdata_o[`TOFM_BIT_FLAG_D];
	assign counter_overflow_flag_o = ovf_q;
	assign match_capture_flag_d_o = flgd_q;
	assign match_capture_interrupt_d_o = flgd_q;

	// Previous counter value and match state for edge detection
	always @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			cnt_prev_q <= `TOFM_CNT_ZERO;
			match_prev_q <= 1'b0;
		end
		else if (clk_en_i)
		begin
			cnt_prev_q <= timer_up_counter_i;
			match_prev_q <= match;
		end
	end

	// Register D: capture copies the counter, otherwise software writes it
	always @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			general_register_d_q <= `TOFM_GRD_RST;
		end
		else if (clk_en_i)
		begin
			if (HAS_D && capmode_q && capture_strobe_i)
			begin
				general_register_d_q <= timer_up_counter_i;
			end
			else if (wr && grd)
			begin
				general_register_d_q <= pwdata_i[15:0];
			end
		end
	end

	always @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			capmode_q <= 1'b0;
		end
		else if (clk_en_i && wr && ctl)
		begin
			capmode_q <= pwdata_i[`TOFM_BIT_CAPMODE];
		end
	end

	// Set wins over a clear in the same cycle
	always @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			ovf_q <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (ovf_set)
			begin
				ovf_q <= 1'b1;
			end
			else if (ovf_clr)
			begin
				ovf_q <= 1'b0;
			end
		end
	end

	always @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			flgd_q <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (d_set)
			begin
				flgd_q <= 1'b1;
			end
			else if (d_clr)
			begin
				flgd_q <= 1'b0;
			end
		end
	end

	// Any status write disarms the software clear
	always @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			ovf_seen_q <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (seen_ovf)
			begin
				ovf_seen_q <= 1'b1;
			end
			else if (wr && sts)
			begin
				ovf_seen_q <= 1'b0;
			end
		end
	end

	always @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			flgd_seen_q <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (seen_d)
			begin
				flgd_seen_q <= 1'b1;
			end
			else if ((wr && sts) || !flgd_q)
			begin
				flgd_seen_q <= 1'b0;
			end
		end
	end

	// Marks that the read word of the current transfer has been fetched
	always @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			rd_loaded_q <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (rd)
			begin
				rd_loaded_q <= 1'b0;
			end
			else if (rd_fetch)
			begin
				rd_loaded_q <= 1'b1;
			end
			else if (!psel_i)
			begin
				rd_loaded_q <= 1'b0;
			end
		end
	end

	always @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			prdata_o <= `TOFM_RDATA_RST;
		end
		else if (clk_en_i && rd_fetch)
		begin
			prdata_o <= rd_word_d;
		end
	end

	// Read multiplexer; unmapped offsets read as zero
	always @*
	begin
		rd_word_d = `TOFM_RDATA_RST;
		case (paddr_i)
			`TOFM_STATUS_OFS:
			begin
				rd_word_d = {27'h0, ovf_q, flgd_q & HAS_D, 3'h0};
			end
			`TOFM_CONTROL_OFS:
			begin
				rd_word_d = {31'h0, capmode_q};
			end
			`TOFM_COUNTER_OFS:
			begin
				rd_word_d = {16'h0, timer_up_counter_i};
			end
			`TOFM_GRD_OFS:
			begin
				rd_word_d = {16'h0, general_register_d_q};
			end
			default:
			begin
				rd_word_d = `TOFM_RDATA_RST;
			end
		endcase
	end
endmodule // tofm_flags

// File: bench/tofm_flags_props.sv
// Checker on the flag outputs of tofm_flags; bound at the foot.
`timescale 1ns/10ps
module tofm_flags_props (
	input wire logic        ref_clk_i, rst_n_i, clk_en_i, psel_i, xfer_start_i,
	input wire logic        transfer_interrupt_select_i, transfer_count_nonzero_i,
	input wire logic        counter_overflow_flag_o, match_capture_flag_d_o,
	input wire logic [15:0] timer_up_counter_i
);
	wire        o = counter_overflow_flag_o;
	wire        f = match_capture_flag_d_o;
	wire        x = xfer_start_i & clk_en_i & transfer_count_nonzero_i & !transfer_interrupt_select_i;
	wire [15:0] t = timer_up_counter_i;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_wrap;
		clk_en_i && t == 16'hFFFF ##1 clk_en_i && t == 16'h0000;
	endsequence
	a_ov_set: assert property (s_wrap |=> o) else $error("overflow not set");
	a_ov_stay: assert property (s_wrap ##1 !psel_i [*3] |=> o) else $error("overflow lost");
	a_ov_hold: assert property (o && !psel_i |=> o) else $error("overflow lost");
	a_ov_idle: assert property (!o && $past(clk_en_i) && $past(t) != 16'hFFFF |=> !o) else $error("overflow");
	a_d_hold: assert property (f && !psel_i && !x |=> f) else $error("flag D lost");
	a_d_stay: assert property (f && !psel_i && !x ##1 !psel_i && !x |=> f) else $error("flag D");
	a_d_xfer: assert property (f && x |=> !f) else $error("flag D kept");
	a_d_xkeep: assert property (f && !x && !psel_i |=> $stable(f)) else $error("flag D");
endmodule // tofm_flags_props
bind tofm_flags tofm_flags_props u_props (.*);

// File: bench/tb.sv
// Bench: APB status reads around counter wrap, capture and controller clear.
`timescale 1ns/10ps
module tb;
	logic        clk=0, rst_n_i=0, clk_en_i=1, psel_i=0, penable_i=0, pwrite_i=0, pready_o;
	logic        capture_strobe_i=0, xfer_start_i=0, transfer_interrupt_select_i=0, pslverr_o;
	logic        transfer_count_nonzero_i=1, counter_overflow_flag_o, match_capture_flag_d_o;
	logic        match_capture_interrupt_d_o;
	logic [11:0] paddr_i=0;
	logic [31:0] pwdata_i=0, prdata_o;
	logic [15:0] timer_up_counter_i=0;
	int          miscompares=0, checks_done=0, n;
	logic [31:0] rdata;
	always #4 clk = ~clk;
	tofm_flags DUT (.ref_clk_i(clk), .*);
	task wrap_up;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t read %h expected %h", $time, got, exp);
		end
	endtask
	task chk_pin(input logic got, input logic exp);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t pin %b expected %b", $time, got, exp);
		end
	endtask
	// Request stands until pready is seen high in the access phase
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk) {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
		@(posedge clk) penable_i <= 1'b1;
		n = 0;
		do @(posedge clk); while (pready_o !== 1'b1 && ++n < 20);
		rdata = prdata_o;
		{psel_i, penable_i} <= 2'b00;
		if (n == 20)
		begin
			miscompares++;
			$display("[ERR] %0t bus timeout", $time);
			wrap_up;
		end
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk_word(rdata, exp);
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		rst_n_i <= 1'b1;
		rd(12'h000, 32'h0);
		chk_pin(counter_overflow_flag_o, 1'b0);
		@(posedge clk) timer_up_counter_i <= 16'hFFFF;
		@(posedge clk) timer_up_counter_i <= 16'h0000;
		rd(12'h000, 32'h18);
		chk_pin(counter_overflow_flag_o, 1'b1);
		chk_pin(match_capture_interrupt_d_o, 1'b1);
		apb(1'b1, 12'h000, 32'h18);
		rd(12'h000, 32'h18);
		apb(1'b1, 12'h000, 32'h0);
		rd(12'h000, 32'h0);
		@(posedge clk) timer_up_counter_i <= 16'hFFFF;
		@(posedge clk) timer_up_counter_i <= 16'h0000;
		apb(1'b1, 12'h000, 32'h0);
		rd(12'h000, 32'h18);
		apb(1'b1, 12'h000, 32'h0);
		rd(12'h000, 32'h0);
		chk_pin(pslverr_o, 1'b0);
		$display("wrap test done");
		apb(1'b1, 12'h00C, 32'h0000_0005);
		@(posedge clk) timer_up_counter_i <= 16'h0005;
		rd(12'h000, 32'h8);
		{clk_en_i, xfer_start_i} <= 2'b01;
		@(posedge clk) {clk_en_i, transfer_interrupt_select_i} <= 2'b11;
		@(posedge clk) {xfer_start_i, transfer_interrupt_select_i} <= 2'b00;
		@(posedge clk) chk_pin(match_capture_flag_d_o, 1'b1);
		xfer_start_i <= 1'b1;
		@(posedge clk) xfer_start_i <= 1'b0;
		@(posedge clk) chk_pin(match_capture_flag_d_o, 1'b0);
		chk_pin(match_capture_interrupt_d_o, 1'b0);
		$display("compare test done");
		apb(1'b1, 12'h004, 32'h1);
		{capture_strobe_i, timer_up_counter_i} <= {1'b1, 16'h0007};
		@(posedge clk) capture_strobe_i <= 1'b0;
		rd(12'h000, 32'h8);
		rd(12'h00C, 32'h7);
		xfer_start_i <= 1'b1;
		@(posedge clk) xfer_start_i <= 1'b0;
		rd(12'h000, 32'h0);
		$display("capture test done");
		wrap_up;
	end
endmodule // tb
